// file: pkg/stap_defines.vh
// Purpose: Constants for the SRAM boundary-scan test port
// Assumes: Three-bit instruction register, 32-bit identification register
// Notes:   Instruction codes other than identification are assumed values
`ifndef STAP_DEFINES_VH
`define STAP_DEFINES_VH

// Controller states
`define STAP_S_RESET   4'h0
`define STAP_S_IDLE    4'h1
`define STAP_S_SEL_DR  4'h2
`define STAP_S_CAP_DR  4'h3
`define STAP_S_SH_DR   4'h4
`define STAP_S_EX1_DR  4'h5
`define STAP_S_PA_DR   4'h6
`define STAP_S_EX2_DR  4'h7
`define STAP_S_UPD_DR  4'h8
`define STAP_S_SEL_IR  4'h9
`define STAP_S_CAP_IR  4'ha
`define STAP_S_SH_IR   4'hb
`define STAP_S_EX1_IR  4'hc
`define STAP_S_PA_IR   4'hd
`define STAP_S_EX2_IR  4'he
`define STAP_S_UPD_IR  4'hf

// Instruction codes
`define STAP_IR_W        3
`define STAP_I_EXTEST    3'h0
`define STAP_I_IDCODE    3'h1
`define STAP_I_SAMPLEZ   3'h2
`define STAP_I_SAMPLE    3'h4
`define STAP_I_BYPASS    3'h7
`define STAP_IR_CAPTURE  2'h1

// Register sizes
`define STAP_ID_W        32
`define STAP_BSR_W       109
`define STAP_BSR_OE_BIT  108
// Arbitrary identification value
`define STAP_ID_VALUE    32'h1234_5001

`endif

// file: rtl/stap_top.v
// Purpose: Boundary-scan test access port of a burst SRAM
// Assumes: Test clock sampled by MCLK_I at 25 MHz, well above its rate
// Notes:   Test clock edges found after a two-flop synchroniser
`include "stap_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module stap_top (
   // Clock and reset
   input  wire                   MCLK_I,
   input  wire                   ARST_N_I,
   // Test port pins
   input  wire                   TCK_I,
   input  wire                   TMS_I,
   input  wire                   TDI_I,
   output reg                    TDO_O,
   output reg                    TDO_OE_O,
   // Pin ring
   input  wire [`STAP_BSR_W-1:0] PIN_RING_I,
   output reg  [`STAP_BSR_W-1:0] BSR_PRELOAD_O,
   output reg                    EXTEST_O,
   output reg                    OUTBUS_EN_O
);

   reg  [1:0]             tck_s_r;
   reg  [1:0]             tms_s_r;
   reg  [1:0]             tdi_s_r;
   reg                    tck_d_r;
   reg  [3:0]             state_r;
   reg  [3:0]             state_nxt;
   reg  [`STAP_IR_W-1:0]  ir_sh_r;
   reg  [`STAP_IR_W-1:0]  ir_r;
   reg                    byp_r;
   reg  [`STAP_ID_W-1:0]  id_r;
   reg  [`STAP_BSR_W-1:0] bsr_r;
   reg                    so_bit;
   wire                   tck_rise;
   wire                   tck_fall;
   wire                   tms;
   wire                   tdi;
   wire                   sel_bsr;

   // Pull-ups are modelled as reset-high synchroniser stages
   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         tck_s_r <= 2'h0;
         tms_s_r <= 2'h3;
         tdi_s_r <= 2'h3;
         tck_d_r <= 1'h0;
      end else begin
         tck_s_r <= {tck_s_r[0], TCK_I};
         tms_s_r <= {tms_s_r[0], TMS_I};
         tdi_s_r <= {tdi_s_r[0], TDI_I};
         tck_d_r <= tck_s_r[1];
      end
   end

   assign tck_rise = tck_s_r[1] & ~tck_d_r;
   assign tck_fall = ~tck_s_r[1] & tck_d_r;
   assign tms      = tms_s_r[1];
   assign tdi      = tdi_s_r[1];
   assign sel_bsr  = (ir_r == `STAP_I_EXTEST) || (ir_r == `STAP_I_SAMPLE) ||
                     (ir_r == `STAP_I_SAMPLEZ);

   // Controller next state; five TMS-high edges reach reset
   always @* begin
      case (state_r)
         `STAP_S_RESET:
            state_nxt = tms ? `STAP_S_RESET  : `STAP_S_IDLE;
         `STAP_S_IDLE:
            state_nxt = tms ? `STAP_S_SEL_DR : `STAP_S_IDLE;
         `STAP_S_SEL_DR:
            state_nxt = tms ? `STAP_S_SEL_IR : `STAP_S_CAP_DR;
         `STAP_S_CAP_DR:
            state_nxt = tms ? `STAP_S_EX1_DR : `STAP_S_SH_DR;
         `STAP_S_SH_DR:
            state_nxt = tms ? `STAP_S_EX1_DR : `STAP_S_SH_DR;
         `STAP_S_EX1_DR:
            state_nxt = tms ? `STAP_S_UPD_DR : `STAP_S_PA_DR;
         `STAP_S_PA_DR:
            state_nxt = tms ? `STAP_S_EX2_DR : `STAP_S_PA_DR;
         `STAP_S_EX2_DR:
            state_nxt = tms ? `STAP_S_UPD_DR : `STAP_S_SH_DR;
         `STAP_S_UPD_DR:
            state_nxt = tms ? `STAP_S_SEL_DR : `STAP_S_IDLE;
         `STAP_S_SEL_IR:
            state_nxt = tms ? `STAP_S_RESET  : `STAP_S_CAP_IR;
         `STAP_S_CAP_IR:
            state_nxt = tms ? `STAP_S_EX1_IR : `STAP_S_SH_IR;
         `STAP_S_SH_IR:
            state_nxt = tms ? `STAP_S_EX1_IR : `STAP_S_SH_IR;
         `STAP_S_EX1_IR:
            state_nxt = tms ? `STAP_S_UPD_IR : `STAP_S_PA_IR;
         `STAP_S_PA_IR:
            state_nxt = tms ? `STAP_S_EX2_IR : `STAP_S_PA_IR;
         `STAP_S_EX2_IR:
            state_nxt = tms ? `STAP_S_UPD_IR : `STAP_S_SH_IR;
         `STAP_S_UPD_IR:
            state_nxt = tms ? `STAP_S_SEL_DR : `STAP_S_IDLE;
         default:
            state_nxt = `STAP_S_RESET;
      endcase
   end

   // Serial output source: IR shifter in Shift-IR, else the data register that ir_r selects
   always @* begin
      if (state_r == `STAP_S_SH_IR)
         so_bit = ir_sh_r[0];
      else begin
         case (ir_r)
            `STAP_I_IDCODE: so_bit = id_r[0];
            `STAP_I_EXTEST,
            `STAP_I_SAMPLE,
            `STAP_I_SAMPLEZ: so_bit = bsr_r[0];
            default:         so_bit = byp_r;
         endcase
      end
   end

   // Rising-edge logic: controller and scan registers
   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_r       <= `STAP_S_RESET;
         ir_sh_r       <= `STAP_I_IDCODE;
         ir_r          <= `STAP_I_IDCODE;
         byp_r         <= 1'h0;
         id_r          <= `STAP_ID_VALUE;
         bsr_r         <= {`STAP_BSR_W{1'h0}};
         BSR_PRELOAD_O <= {{(`STAP_BSR_W-1){1'h0}}, 1'h1} <<
                          `STAP_BSR_OE_BIT;
      end else if (tck_rise) begin
         state_r <= state_nxt;
         case (state_r)
            `STAP_S_CAP_IR:
               ir_sh_r <= {ir_sh_r[`STAP_IR_W-1:2], `STAP_IR_CAPTURE};
            `STAP_S_SH_IR:
               ir_sh_r <= {tdi, ir_sh_r[`STAP_IR_W-1:1]};
            `STAP_S_UPD_IR: begin
               ir_r <= ir_sh_r;
               if (ir_sh_r == `STAP_I_BYPASS)
                  byp_r <= 1'h0;
            end
            `STAP_S_CAP_DR: begin
               if (ir_r == `STAP_I_IDCODE)
                  id_r <= `STAP_ID_VALUE;
               else if (sel_bsr)
                  bsr_r <= PIN_RING_I;
               else
                  byp_r <= 1'h0;
            end
            `STAP_S_SH_DR: begin
               if (ir_r == `STAP_I_IDCODE)
                  id_r <= {tdi, id_r[`STAP_ID_W-1:1]};
               else if (sel_bsr)
                  bsr_r <= {tdi, bsr_r[`STAP_BSR_W-1:1]};
               else
                  byp_r <= tdi;
            end
            `STAP_S_UPD_DR:
               if (sel_bsr)
                  BSR_PRELOAD_O <= bsr_r;
            default: ;
         endcase
         // Load on the edge that enters reset, not one test clock later
         if (state_nxt == `STAP_S_RESET) begin
            ir_r <= `STAP_I_IDCODE;
            BSR_PRELOAD_O[`STAP_BSR_OE_BIT] <= 1'h1;
         end
      end
   end

   // Falling-edge logic: serial output and its enable; mode outputs follow ir_r and, in EXTEST, the preload enable cell on every system clock
   always @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         TDO_O       <= 1'h0;
         TDO_OE_O    <= 1'h0;
         EXTEST_O    <= 1'h0;
         OUTBUS_EN_O <= 1'h1;
      end else begin
         if (tck_fall) begin
            TDO_O    <= so_bit;
            TDO_OE_O <= (state_r == `STAP_S_SH_IR) ||
                        (state_r == `STAP_S_SH_DR);
         end
         EXTEST_O    <= (ir_r == `STAP_I_EXTEST);
         OUTBUS_EN_O <= (ir_r == `STAP_I_EXTEST) ?
                        BSR_PRELOAD_O[`STAP_BSR_OE_BIT] :
                        (ir_r != `STAP_I_SAMPLEZ);
      end
   end

endmodule // stap_top

`default_nettype wire

// file: bench/stap_monitor.sv
// Purpose: Assertions on the test port pins
// Assumes: Test clock high and low for four system clocks each
// Notes:   Counts test clock rises with mode select high
`timescale 1ns/1ps
`default_nettype none
module stap_monitor (
   // Clock, reset and test pins
   input wire logic         MCLK_I, ARST_N_I, TCK_I, TMS_I, TDI_I,
   input wire logic         TDO_O, TDO_OE_O, EXTEST_O, OUTBUS_EN_O,
   // Pin ring
   input wire logic [108:0] PIN_RING_I, BSR_PRELOAD_O
);
   logic       tck_q_r;
   logic [2:0] cnt_r;
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         tck_q_r <= 1'b0;
         cnt_r   <= 3'h0;
      end else begin
         tck_q_r <= TCK_I;
         if (TCK_I && !tck_q_r)
            cnt_r <= !TMS_I ? 3'h0 : (cnt_r == 3'h5) ? cnt_r : cnt_r + 3'h1;
      end
   end
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   property p_tdo_fall; $changed(TDO_O) |-> !TCK_I; endproperty
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("serial out moved with clock high");
   property p_oe_fall; $changed(TDO_OE_O) |-> !TCK_I; endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("enable moved with clock high");
   property p_tms_rst; cnt_r == 3'h5 |-> ##8 !TDO_OE_O && !EXTEST_O; endproperty
   a_tms_rst: assert property (p_tms_rst)
      else $error("no reset after five high mode bits");
   property p_exit_oe;
      TDO_OE_O && TMS_I && $rose(TCK_I) |-> ##[1:10] !TDO_OE_O;
   endproperty
   a_exit_oe: assert property (p_exit_oe)
      else $error("enable held after shift exit");
   property p_outbus;
      (EXTEST_O && $stable(BSR_PRELOAD_O))[*3] |-> OUTBUS_EN_O == BSR_PRELOAD_O[108];
   endproperty
   a_outbus: assert property (p_outbus)
      else $error("bus enable differs from cell");
   property p_rst_vals;
      !$past(ARST_N_I) |-> OUTBUS_EN_O && BSR_PRELOAD_O[108] && !TDO_OE_O && !EXTEST_O;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("bad values after reset");
   property p_ir_hold; $changed(EXTEST_O) |-> !TDO_OE_O; endproperty
   a_ir_hold: assert property (p_ir_hold)
      else $error("instruction moved while shifting");
   property p_bsr_hold; $changed(BSR_PRELOAD_O) |-> !TDO_OE_O; endproperty
   a_bsr_hold: assert property (p_bsr_hold)
      else $error("preload moved while shifting");
   c_tms_rst: cover property (cnt_r == 3'h5);
   c_exit: cover property (TDO_OE_O ##1 !TDO_OE_O);
   c_tristate: cover property (EXTEST_O && !OUTBUS_EN_O);
endmodule // stap_monitor
`default_nettype wire

// file: bench/stap_host.sv
// Purpose: Boundary-scan controller model
// Assumes: Test clock period of eight system clocks
// Notes:   Serial input idles high as its pull-up would
`timescale 1ns/1ps
`default_nettype none
module stap_host (
   // System clock and serial return
   input  wire logic mclk,
   input  wire logic tdo,
   // Test pins
   output var  logic tck, tms, tdi
);
   initial {tck, tms, tdi} = 3'b011;
   task automatic step(input logic m, d, output logic o);
      @(posedge mclk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge mclk);
      o = tdo;
      tck <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic scan(input logic ir, input int n,
                       input logic [127:0] din, output logic [127:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b1, o);
      if (ir)
         step(1'b1, 1'b1, o);
      repeat (2) step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      // Registered outputs follow the update edge by one system clock
      repeat (2) @(negedge mclk);
   endtask
endmodule // stap_host
`default_nettype wire

// file: bench/stap_tb_top.sv
// Purpose: Self-checking bench for the test port
// Assumes: Design takes test pins through synchronisers
// Notes:   Expected values pass through a queue to a watcher
`timescale 1ns/1ps
`default_nettype none
`include "stap_defines.vh"
module stap_tb_top;
   logic         mclk, arst_n, tck, tms, tdi, tdo, tdo_oe, extest, oben;
   logic [108:0] ring, pre;
   logic [127:0] got, e, d, r;
   logic [127:0] exp_q [$];
   logic [31:0]  seed = 32'd31886;
   int           num_errors = 0, check_count = 0, cyc = 0;
   event         res_ev;
   stap_top dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .TCK_I(tck), .TMS_I(tms),
      .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PIN_RING_I(ring),
      .BSR_PRELOAD_O(pre), .EXTEST_O(extest), .OUTBUS_EN_O(oben));
   stap_host host (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [127:0] x, v);
      exp_q.push_back(x);
      got = v;
      -> res_ev;
      @(posedge mclk);
   endtask
   task close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(res_ev) begin
      e = exp_q.pop_front();
      check_count++;
      if (e !== got) begin
         num_errors++;
         $display("[ERR] %0t exp %h got %h", $time, e, got);
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      logic       o;
      logic [2:0] codes [4];
      codes = '{3'h3, 3'h5, 3'h6, `STAP_I_BYPASS};
      arst_n = 1'b0;
      ring = '0;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      host.step(1'b0, 1'b1, o);
      host.scan(1'b0, 32, '1, r);
      chk(`STAP_ID_VALUE, r);
      $display("test idcode done");
      foreach (codes[k]) begin
         host.scan(1'b1, 3, codes[k], r);
         chk(`STAP_IR_CAPTURE, r[1:0]);
         d = xs();
         host.scan(1'b0, 8, d, r);
         chk({d[6:0], 1'b0}, r[7:0]);
      end
      $display("test bypass done");
      for (int j = 0; j < 2; j++) begin
         d = {xs(), xs(), xs(), xs()};
         ring <= d[108:0];
         host.scan(1'b1, 3, j ? `STAP_I_EXTEST : `STAP_I_SAMPLE, r);
         chk({j[0], ~j[0]}, {extest, oben});
         d = {xs(), xs(), xs(), xs()};
         d[108] = j[0];
         host.scan(1'b0, 109, d, r);
         chk(ring, r[108:0]);
         chk(d[108:0], pre);
         chk({j[0], 1'b1}, {extest, oben});
      end
      host.scan(1'b1, 3, `STAP_I_SAMPLEZ, r);
      chk(2'b00, {extest, oben});
      $display("test boundary done");
      host.step(1'b1, 1'b1, o);
      repeat (2) host.step(1'b0, 1'b1, o);
      repeat (5) host.step(1'b1, 1'b1, o);
      host.step(1'b0, 1'b1, o);
      chk(2'b01, {extest, oben});
      host.scan(1'b0, 32, '0, r);
      chk(`STAP_ID_VALUE, r);
      $display("test mode reset done");
      close_out();
   end
endmodule // stap_tb_top
bind stap_top stap_monitor mon (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
   .TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I), .TDO_O(TDO_O),
   .TDO_OE_O(TDO_OE_O), .EXTEST_O(EXTEST_O), .OUTBUS_EN_O(OUTBUS_EN_O),
   .PIN_RING_I(PIN_RING_I), .BSR_PRELOAD_O(BSR_PRELOAD_O));
`default_nettype wire
